// ---- hdl/timer_h1_params.svh ----
// Register map, field positions, reset values and divider settings
`ifndef TIMER_H1_PARAMS_SVH
`define TIMER_H1_PARAMS_SVH
`define ADDR_PORT1_DIR 16'hff21
`define ADDR_MODE_CTL 16'hff6c
`define ADDR_CARRIER_CTL 16'hff6d
`define ADDR_CMP_FIRST 16'hff6e
`define ADDR_CMP_SECOND 16'hff6f
`define RST_PORT1_DIR 8'hff
`define RST_MODE_CTL 8'h00
`define RST_CARRIER_CTL 8'h00
`define RST_CMP 8'h00
`define BIT_PIN6 6
`define PRS_LOG2_D4 2
`define PRS_LOG2_D16 4
`define PRS_LOG2_D64 6
`define PRS_LOG2_D4096 12
`define LSO_LOG2_D128 7
`define LSO_LOG2_D512 9
`define PRE_W 12
`define LSO_W 9
`endif

// ---- hdl/timer_h1_pkg.sv ----
// Types shared by the timer H1 block
`default_nettype none
package timer_h1_pkg;
	typedef enum logic [1:0] {
		MODE_INTERVAL = 2'b00,
		MODE_CARRIER = 2'b01,
		MODE_PWM = 2'b10,
		MODE_BAD = 2'b11
	} tmode_t;
	typedef enum logic [2:0] {
		CLK_PRS = 3'b000,
		CLK_PRS_D4 = 3'b001,
		CLK_PRS_D16 = 3'b010,
		CLK_PRS_D64 = 3'b011,
		CLK_PRS_D4096 = 3'b100,
		CLK_LSO_D128 = 3'b101,
		CLK_LSO_D512 = 3'b110,
		CLK_LSO = 3'b111
	} clk_src_t;
	typedef struct packed {
		logic run;
		clk_src_t clk_sel;
		tmode_t mode;
		logic def_level;
		logic gate;
	} mode_ctl_t;
	typedef struct packed {
		logic [4:0] rsvd;
		logic car_en;
		logic pend;
		logic applied;
	} carrier_ctl_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} bus_req_t;
	typedef struct packed {
		logic o;
		logic oe;
	} pin_t;
endpackage
`default_nettype wire

// ---- hdl/timer_h1_mode_and_interval.sv ----
// Timer H1 mode, carrier control, port direction and interval counter
`default_nettype none
`include "timer_h1_params.svh"
// Contract
// R1 - Run bit low stops counting and holds the counter at zero.
// R2 - Clock field picks prescaled peripheral or low-speed oscillator.
// R3 - Mode field: 00 interval, 01 carrier, 10 PWM, 11 forbidden.
// R4 - Default level bit sets the idle output level.
// R5 - Output gate bit enables the waveform onto the output.
// R6 - Software changes no other mode bit while running.
// R7 - Software rewrites second compare on every restart in PWM/carrier.
// R8 - Software keeps this count clock over six times the companion's.
// R9 - Carrier control resets to zero and takes bit or byte writes.
// R10 - Remote output: 00 low, 01 high, 10 low, 11 carrier pulses.
// R11 - Bit 0 of carrier control is read-only applied-level status.
// R12 - Direction bit 6 at 0 drives pin, resets to all ones.
// R13 - Interval match with first compare raises irq, clears counter.
// R14 - Interval mode ignores the second compare entirely.
// R15 - Each first compare match inverts the output level.
// R16 - Irq interval equals compare value plus one count clocks.
// R17 - Counting starts within one count clock after run is set.
// R18 - Match irq comes on the count clock edge of the match.
// R19 - Stopping returns irq and output to default levels; in carrier mode the output still follows applied_q and car_en.
// R20 - Mode register resets to zero and takes bit or byte writes.
// R21 - Eight-bit counter increments once per selected count clock.
module timer_h1_mode_and_interval #(
	parameter int CNT_W = 8,
	parameter int PRE_W = `PRE_W,
	parameter int LSO_W = `LSO_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire timer_h1_pkg::bus_req_t bus,
	output logic [7:0] rdata,
	input wire logic lso_clk_pin,
	input wire logic companion_event,
	output logic match_irq,
	output var timer_h1_pkg::pin_t timer_out_pin,
	output logic [7:0] port1_oe
);
	import timer_h1_pkg::*;

	if (CNT_W != 8 || PRE_W < 12 || LSO_W < 9) begin : g_bad_param
		$error("Unsupported timer parameters");
	end

	function automatic logic addr_hit(input logic [15:0] a,
		input logic [15:0] r);
		return a == r;
	endfunction

	function automatic logic low_ones(input logic [PRE_W-1:0] v,
		input int n);
		logic [PRE_W-1:0] m;
		m = PRE_W'((64'd1 << n) - 64'd1);
		return (v & m) == m;
	endfunction

	// Register file
	mode_ctl_t mode_q;
	mode_ctl_t mode_d;
	mode_ctl_t wr_mode;
	carrier_ctl_t car_q;
	carrier_ctl_t car_d;
	logic [7:0] dir_q;
	logic [7:0] dir_d;
	logic [7:0] cmp0_q;
	logic [7:0] cmp0_d;
	logic [7:0] cmp1_buf_q;
	logic [7:0] cmp1_buf_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic applied_q;
	logic wr_cmp1;

	assign wr_mode = mode_ctl_t'(bus.wdata);
	assign wr_cmp1 = bus.we && addr_hit(bus.addr, `ADDR_CMP_SECOND);

	always_comb begin
		mode_d = mode_q;
		car_d = car_q;
		dir_d = dir_q;
		cmp0_d = cmp0_q;
		cmp1_buf_d = cmp1_buf_q;
		rdata_d = 8'h00;
		if (bus.we) begin
			if (addr_hit(bus.addr, `ADDR_MODE_CTL)) begin
				mode_d = wr_mode;
				if (wr_mode.mode == MODE_BAD) begin
					mode_d.mode = mode_q.mode; // see R3
				end
			end
			if (addr_hit(bus.addr, `ADDR_CARRIER_CTL)) begin
				car_d = carrier_ctl_t'(bus.wdata);
				car_d.rsvd = 5'h00;
				car_d.applied = 1'b0; // see R11
			end
			if (addr_hit(bus.addr, `ADDR_PORT1_DIR)) begin
				dir_d = bus.wdata;
			end
			if (addr_hit(bus.addr, `ADDR_CMP_FIRST)) begin
				cmp0_d = bus.wdata;
			end
			if (wr_cmp1) begin
				cmp1_buf_d = bus.wdata;
			end
		end
		if (bus.re) begin
			if (addr_hit(bus.addr, `ADDR_MODE_CTL)) begin
				rdata_d = mode_q;
			end
			if (addr_hit(bus.addr, `ADDR_CARRIER_CTL)) begin
				rdata_d = {car_q[7:1], applied_q}; // see R11
			end
			if (addr_hit(bus.addr, `ADDR_PORT1_DIR)) begin
				rdata_d = dir_q;
			end
			if (addr_hit(bus.addr, `ADDR_CMP_FIRST)) begin
				rdata_d = cmp0_q;
			end
			if (addr_hit(bus.addr, `ADDR_CMP_SECOND)) begin
				rdata_d = cmp1_buf_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= mode_ctl_t'(`RST_MODE_CTL); // see R20
			car_q <= carrier_ctl_t'(`RST_CARRIER_CTL); // see R9
			dir_q <= `RST_PORT1_DIR; // see R12
			cmp0_q <= `RST_CMP;
			cmp1_buf_q <= `RST_CMP;
			rdata_q <= 8'h00;
		end else if (ce) begin
			mode_q <= mode_d;
			car_q <= car_d;
			dir_q <= dir_d;
			cmp0_q <= cmp0_d;
			cmp1_buf_q <= cmp1_buf_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;
	assign port1_oe = ~dir_q; // see R12

	// Count clock sources
	logic lso_s1_q;
	logic lso_s1_d;
	logic lso_s2_q;
	logic lso_s2_d;
	logic lso_s3_q;
	logic lso_s3_d;
	logic [PRE_W-1:0] prs_q;
	logic [PRE_W-1:0] prs_d;
	logic [LSO_W-1:0] lso_q;
	logic [LSO_W-1:0] lso_d;
	logic lso_edge;
	logic tick;

	assign lso_edge = lso_s2_q & ~lso_s3_q;

	always_comb begin
		lso_s1_d = lso_clk_pin;
		lso_s2_d = lso_s1_q;
		lso_s3_d = lso_s2_q;
		prs_d = prs_q + 1'b1;
		lso_d = lso_q;
		if (lso_edge) begin
			lso_d = lso_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lso_s1_q <= 1'b0;
			lso_s2_q <= 1'b0;
			lso_s3_q <= 1'b0;
			prs_q <= '0;
			lso_q <= '0;
		end else if (ce) begin
			lso_s1_q <= lso_s1_d;
			lso_s2_q <= lso_s2_d;
			lso_s3_q <= lso_s3_d;
			prs_q <= prs_d;
			lso_q <= lso_d;
		end
	end

	always_comb begin
		case (mode_q.clk_sel) // see R2
			CLK_PRS: begin
				tick = 1'b1;
			end
			CLK_PRS_D4: begin
				tick = low_ones(prs_q, `PRS_LOG2_D4);
			end
			CLK_PRS_D16: begin
				tick = low_ones(prs_q, `PRS_LOG2_D16);
			end
			CLK_PRS_D64: begin
				tick = low_ones(prs_q, `PRS_LOG2_D64);
			end
			CLK_PRS_D4096: begin
				tick = low_ones(prs_q, `PRS_LOG2_D4096);
			end
			CLK_LSO_D128: begin
				tick = lso_edge &&
					low_ones(PRE_W'(lso_q), `LSO_LOG2_D128);
			end
			CLK_LSO_D512: begin
				tick = lso_edge &&
					low_ones(PRE_W'(lso_q), `LSO_LOG2_D512);
			end
			default: begin
				tick = lso_edge;
			end
		endcase
	end

	// Counter, output level and carrier transfer
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [7:0] cmp1_q;
	logic [7:0] cmp1_d;
	logic cmp1_new_q;
	logic cmp1_new_d;
	logic level_q;
	logic level_d;
	logic irq_q;
	logic irq_d;
	logic applied_d;
	logic evt_q;
	logic evt_d;
	pin_t pin_q;
	pin_t pin_d;
	logic hit0;
	logic hit1;
	logic lvl_gated;

	assign hit0 = cnt_q == cmp0_q;
	assign hit1 = cnt_q == cmp1_q;

	always_comb begin
		cnt_d = cnt_q;
		cmp1_d = cmp1_q;
		cmp1_new_d = cmp1_new_q | wr_cmp1;
		level_d = level_q;
		irq_d = 1'b0;
		applied_d = applied_q;
		evt_d = evt_q | companion_event;
		if (tick && evt_d) begin
			applied_d = car_q.pend;
			evt_d = 1'b0;
		end
		if (!mode_q.run) begin
			cnt_d = '0; // see R1
			level_d = mode_q.def_level; // see R19
			cmp1_d = cmp1_buf_q;
			cmp1_new_d = 1'b0;
		end else if (tick) begin // see R17
			if (hit0) begin
				cnt_d = '0; // see R13, R16
				level_d = ~level_q; // see R15
				irq_d = 1'b1; // see R18
			end else begin
				cnt_d = cnt_q + 1'b1; // see R21
				if (mode_q.mode == MODE_PWM && hit1) begin
					level_d = ~level_q; // see R14
					if (cmp1_new_q && !wr_cmp1) begin
						cmp1_d = cmp1_buf_q;
						cmp1_new_d = 1'b0;
					end
				end
			end
		end
		lvl_gated = mode_q.gate ? level_q : mode_q.def_level; // see R5
		if (mode_q.mode == MODE_CARRIER) begin
			pin_d.o = applied_q & (~car_q.car_en | lvl_gated); // see R10
		end else begin
			pin_d.o = lvl_gated; // see R4
		end
		pin_d.oe = ~dir_q[`BIT_PIN6];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			cmp1_q <= `RST_CMP;
			cmp1_new_q <= 1'b0;
			level_q <= 1'b0;
			irq_q <= 1'b0;
			applied_q <= 1'b0;
			evt_q <= 1'b0;
			pin_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			cmp1_q <= cmp1_d;
			cmp1_new_q <= cmp1_new_d;
			level_q <= level_d;
			irq_q <= irq_d;
			applied_q <= applied_d;
			evt_q <= evt_d;
			pin_q <= pin_d;
		end
	end

	assign match_irq = irq_q;
	assign timer_out_pin = pin_q;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_stop_zero;
		ce && !mode_q.run |=> cnt_q == '0 && !match_irq;
	endproperty
	a_stop_zero: assert property (p_stop_zero) // see R1
		else $error("Counter not held at zero while stopped");
	property p_div4;
		mode_q.clk_sel == CLK_PRS_D4 && tick |-> prs_q[1:0] == 2'b11;
	endproperty
	a_div4: assert property (p_div4) // see R2
		else $error("Divide by four tick off phase");
	property p_mode_reject;
		ce && bus.we && addr_hit(bus.addr, `ADDR_MODE_CTL) &&
			wr_mode.mode == MODE_BAD |=> mode_q.mode == $past(mode_q.mode);
	endproperty
	a_mode_reject: assert property (p_mode_reject) // see R3
		else $error("Forbidden mode value was stored");
	property p_rst_vals;
		$fell(rst) |-> car_q == 8'h00 && applied_q == 1'b0;
	endproperty
	a_rst_vals: assert property (p_rst_vals) // see R9
		else $error("Carrier control not zero after reset");
	property p_mode_rst;
		$fell(rst) |-> mode_q == 8'h00 && dir_q == 8'hff;
	endproperty
	a_mode_rst: assert property (p_mode_rst) // see R20
		else $error("Mode or direction wrong after reset");
	property p_remote;
		ce && mode_q.mode == MODE_CARRIER && !car_q.car_en
			|=> timer_out_pin.o == $past(applied_q);
	endproperty
	a_remote: assert property (p_remote) // see R10
		else $error("Remote output does not follow level");
	property p_flag_read;
		ce && bus.re && addr_hit(bus.addr, `ADDR_CARRIER_CTL)
			|=> rdata[0] == $past(applied_q);
	endproperty
	a_flag_read: assert property (p_flag_read) // see R11
		else $error("Status flag read wrong");
	property p_match;
		ce && mode_q.run && tick && hit0
			|=> cnt_q == '0 && match_irq && level_q != $past(level_q);
	endproperty
	a_match: assert property (p_match) // see R13
		else $error("Match did not clear, toggle and raise irq");

	property p_cmp1_ignored;
		ce && mode_q.run && tick && mode_q.mode == MODE_INTERVAL &&
			!hit0 |=> !match_irq && level_q == $past(level_q);
	endproperty
	a_cmp1_ignored: assert property (p_cmp1_ignored) // see R14
		else $error("Output changed without first compare match");
	property p_step;
		ce && mode_q.run && tick && !hit0 |=> cnt_q == $past(cnt_q) + 8'h01;
	endproperty
	a_step: assert property (p_step) // see R16
		else $error("Counter did not advance by one");

	property p_irq_cause;
		match_irq |-> $past(ce) && $past(mode_q.run) && $past(tick) &&
			$past(hit0);
	endproperty
	a_irq_cause: assert property (p_irq_cause) // see R18
		else $error("Irq without a count clock match");

	property p_stop_default;
		ce && !mode_q.run && mode_q.mode != MODE_CARRIER ##1
			ce && !mode_q.run && $stable(mode_q) |=>
			timer_out_pin.o == $past(mode_q.def_level) &&
			level_q == $past(mode_q.def_level);
	endproperty
	a_stop_default: assert property (p_stop_default) // see R19
		else $error("Output not at default while stopped");

	property p_dir_oe;
		ce && bus.we && addr_hit(bus.addr, `ADDR_PORT1_DIR) ##1 ce
			|=> timer_out_pin.oe == !$past(bus.wdata[`BIT_PIN6], 2);
	endproperty
	a_dir_oe: assert property (p_dir_oe) // see R12
		else $error("Pin enable does not follow direction bit");
endmodule
`default_nettype wire

// ---- sim/companion_model.sv ----
// Companion event timer, low-speed oscillator and pin load
`default_nettype none
module companion_model (
	input wire logic clk,
	input wire logic fire,
	input wire timer_h1_pkg::pin_t pin,
	output logic event_o,
	output logic lso_clk,
	output logic pad
);
	timeunit 1ns;
	timeprecision 1ps;
	import timer_h1_pkg::*;
	// Event pulses spaced far apart
	always @(posedge clk) event_o <= fire;
	// Oscillator runs free, unrelated phase
	initial begin
		lso_clk = 1'b0;
		#13;
		forever #160 lso_clk = ~lso_clk;
	end
	// Pull-up when pin is not driven
	assign pad = pin.oe ? pin.o : 1'b1;
endmodule
`default_nettype wire

// ---- sim/timer_h1_mode_and_interval_tb.sv ----
// Self-checking bench for timer H1 mode and interval logic
`default_nettype none
`include "timer_h1_params.svh"
module timer_h1_mode_and_interval_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_h1_pkg::*;
	typedef struct {int lo; int hi;} span_t;
	logic clk, rst, ce, fire, lso, pad, irq, ev;
	bus_req_t bus;
	logic [7:0] rdata, p1oe, n;
	pin_t pin;
	int num_errors = 0, total_checks = 0, hi;
	logic [31:0] rng = 32'h5fcc;
	logic [7:0] rdq[$];
	span_t sq[$];
	int cyc = 0, mark = 0, last = 0;
	logic watch = 0, rdp = 0, irqd = 0, def = 0, gate = 0, fst = 0;
	logic [7:0] nirq = 0;
	int div[8] = '{1, 4, 16, 64, 4096, 1024, 4096, 8};
	span_t sp[4] = '{'{0, 0}, '{16, 16}, '{0, 0}, '{8, 8}};

	timer_h1_mode_and_interval uut (.clk(clk), .rst(rst), .ce(ce),
		.bus(bus), .rdata(rdata), .lso_clk_pin(lso),
		.companion_event(ev), .match_irq(irq),
		.timer_out_pin(pin), .port1_oe(p1oe));
	companion_model far (.clk(clk), .fire(fire), .pin(pin),
		.event_o(ev), .lso_clk(lso), .pad(pad));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic span(input int got, input span_t s);
		total_checks++;
		if (got < s.lo || got > s.hi) begin
			num_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, s.lo);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		rdq.push_back(e);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
	endtask

	task automatic test_done();
		$display("TB: checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wait_for(input int lim);
		for (int i = 0; i < lim && sq.size() > 0; i++) @(posedge clk);
		if (sq.size() > 0) begin
			num_errors++;
			test_done();
		end
	endtask

	// Monitor: read data, irq spacing, output level after each match
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rdp <= bus.re;
		irqd <= irq & watch;
		if (!watch) begin
			fst <= 1'b0;
			nirq <= 8'h00;
		end
		if (rdp) chk(rdata, rdq.pop_front());
		if (irq && watch) begin
			nirq <= nirq + 8'h01;
			last <= cyc;
			fst <= 1'b1;
			if (sq.size() > 0) span(fst ? cyc - last : cyc - mark,
				sq.pop_front());
		end
		if (irqd) chk(pin.o, def ^ (gate & nirq[0]));
	end

	task automatic run_int(input logic [2:0] s, input logic [7:0] v,
		input logic d, g);
		logic [7:0] m;
		m = {1'b0, s, 2'b00, d, g};
		def = d;
		gate = g;
		wr(`ADDR_CMP_FIRST, v);
		rng = lfsr(rng);
		wr(`ADDR_CMP_SECOND, rng[7:0]);
		wr(`ADDR_MODE_CTL, m);
		rd(`ADDR_MODE_CTL, m);
		@(posedge clk) chk(pin.o, d);
		sq.push_back('{v * div[s], (v + 1) * div[s] + 6});
		sq.push_back('{(v + 1) * div[s], (v + 1) * div[s]});
		sq.push_back('{(v + 1) * div[s], (v + 1) * div[s]});
		watch = 1'b1;
		wr(`ADDR_MODE_CTL, m | 8'h80);
		mark = cyc;
		wait_for(3 * (v + 2) * div[s] + 20);
		watch = 1'b0;
		wr(`ADDR_MODE_CTL, m);
		repeat (3) @(posedge clk);
		chk(pin.o, d);
		chk(irq, 1'b0);
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		bus = '0;
		fire = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(`ADDR_PORT1_DIR, `RST_PORT1_DIR);
		rd(`ADDR_MODE_CTL, `RST_MODE_CTL);
		rd(`ADDR_CARRIER_CTL, `RST_CARRIER_CTL);
		rd(`ADDR_CMP_FIRST, `RST_CMP);
		rd(16'hff70, 8'h00);
		chk(p1oe, 8'h00);
		$display("TB: reset test done");
		rng = lfsr(rng);
		wr(`ADDR_PORT1_DIR, rng[7:0]);
		rd(`ADDR_PORT1_DIR, rng[7:0]);
		chk(p1oe ^ rng[7:0], 8'hff);
		chk(pin.oe ^ rng[6], 1'b1);
		wr(`ADDR_MODE_CTL, 8'h7a);
		rd(`ADDR_MODE_CTL, 8'h7a);
		wr(`ADDR_MODE_CTL, 8'h0c);
		rd(`ADDR_MODE_CTL, 8'h08);
		wr(`ADDR_CARRIER_CTL, 8'hff);
		rd(`ADDR_CARRIER_CTL, 8'h06);
		ce <= 1'b0;
		wr(`ADDR_CMP_FIRST, 8'h5a);
		ce <= 1'b1;
		rd(`ADDR_CMP_FIRST, `RST_CMP);
		wr(`ADDR_PORT1_DIR, 8'hbf);
		$display("TB: register test done");
		for (int s = 0; s < 8; s++) begin
			rng = lfsr(rng);
			n = div[s] > 64 ? 8'h01 : {3'b000, rng[4:0]} | 8'h01;
			run_int(s[2:0], n, s[0], s != 2);
		end
		run_int(3'd0, 8'hfe, 1'b0, 1'b1);
		$display("TB: interval test done");
		wr(`ADDR_CMP_FIRST, 8'h01);
		wr(`ADDR_CMP_SECOND, 8'h00);
		wr(`ADDR_MODE_CTL, 8'h05);
		wr(`ADDR_MODE_CTL, 8'h85);
		for (int i = 0; i < 4; i++) begin
			wr(`ADDR_CARRIER_CTL, {5'b00000, i[1:0], 1'b0});
			@(posedge clk) fire <= 1'b1;
			@(posedge clk) fire <= 1'b0;
			repeat (6) @(posedge clk);
			rd(`ADDR_CARRIER_CTL, {5'b00000, i[1:0], i[0]});
			hi = 0;
			repeat (16) @(posedge clk) hi += pad;
			span(hi, sp[i]);
		end
		wr(`ADDR_MODE_CTL, 8'h05);
		$display("TB: carrier test done");
		test_done();
	end
endmodule
`default_nettype wire
